// ==== rtl/fault_flag_and_sequencer.sv ====
// supervisory sequencer, fault classifier and ahb-lite register slave
// assumes comparator status inputs asynchronous, master reset a level input
`timescale 1ns/1ns
module fault_flag_and_sequencer
   import seq_pkg::*;
#(
   parameter int unsigned EN_OFF_CYC = ns_to_cyc(EN_OFF_DLY_NS)
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic logic_enable_i,
   input wire logic ignition_enable_a_i,
   input wire logic ignition_enable_b_i,
   input wire logic master_reset_i,
   input wire logic soft_start_low_i,
   input wire logic pre_regulator_uv_i,
   input wire logic buck_output_uv_i,
   input wire logic ldo_3p3_uv_i,
   input wire logic ldo_5v_uv_i,
   input wire logic tracking_ldo_uv_i,
   input wire logic any_ov_i,
   input wire logic tracking_ldo_disc_i,
   input wire logic hiccup_i,
   input wire logic thermal_shutdown_i,
   input wire logic watchdog_fault_i,
   input wire logic hsel_i,
   input wire logic [31:0] haddr_i,
   input wire logic [1:0] htrans_i,
   input wire logic hwrite_i,
   input wire logic [2:0] hsize_i,
   input wire logic [31:0] hwdata_i,
   input wire logic hready_i,
   output logic [31:0] hrdata_o,
   output logic hreadyout_o,
   output logic hresp_o,
   output logic pre_regulator_on_o,
   output logic buck_on_o,
   output logic ldos_on_o,
   output logic power_good_reset_n_o,
   output logic five_volt_good_o,
   output logic fault_code_bit0_o,
   output logic fault_code_bit0_oe_o,
   output logic fault_code_bit1_o,
   output logic fault_code_bit1_oe_o,
   output logic irq_o
);
   import seq_pkg::*;
   localparam int unsigned UV_CYC = ns_to_cyc(FLAG_UV_DLY_NS);
   localparam int unsigned OV_CYC = ns_to_cyc(OV_DLY_NS);
   localparam int unsigned SYN_W = 14;
   initial begin
      if (EN_OFF_CYC < 1 || EN_OFF_CYC >= (1 << CNT_W)) $error("enable-off delay out of range");
   end

   // two-stage synchronisers for all comparator pins
   logic [SYN_W-1:0] pin_raw, syn1_q, syn2_q;
   assign pin_raw = {logic_enable_i, ignition_enable_a_i, ignition_enable_b_i, master_reset_i,
                     soft_start_low_i, pre_regulator_uv_i, buck_output_uv_i, ldo_3p3_uv_i,
                     ldo_5v_uv_i, tracking_ldo_uv_i, any_ov_i, tracking_ldo_disc_i,
                     hiccup_i, thermal_shutdown_i};
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         syn1_q <= '0;
         syn2_q <= '0;
      end else begin
         syn1_q <= pin_raw;
         syn2_q <= syn1_q;
      end
   end
   logic wd_s1_q, wd_s2_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wd_s1_q <= 1'b0;
         wd_s2_q <= 1'b0;
      end else begin
         wd_s1_q <= watchdog_fault_i;
         wd_s2_q <= wd_s1_q;
      end
   end
   logic en_s, mrst_s, ss_low_s, pre_uv_s, buck_uv_s, uv33_s, uv5_s, trk_uv_s;
   logic ov_s, disc_s, hic_s, tsd_s;
   assign en_s = syn2_q[13] | syn2_q[12] | syn2_q[11];
   assign mrst_s = syn2_q[10];
   assign ss_low_s = syn2_q[9];
   assign pre_uv_s = syn2_q[8];
   assign buck_uv_s = syn2_q[7];
   assign uv33_s = syn2_q[6];
   assign uv5_s = syn2_q[5];
   assign trk_uv_s = syn2_q[4];
   assign ov_s = syn2_q[3];
   assign disc_s = syn2_q[2];
   assign hic_s = syn2_q[1];
   assign tsd_s = syn2_q[0];
   logic ldo_uv_s;
   assign ldo_uv_s = uv33_s | uv5_s | trk_uv_s;

   // software control: force-off bit steers the combined enable
   logic sw_off_q;
   logic en_eff;
   assign en_eff = en_s & ~sw_off_q;

   // filters: enable-off delay, overvoltage delay, undervoltage class delay
   delay_if en_d ();
   delay_if ov_d ();
   delay_if uv_d ();
   seq_state_t st_q;
   assign en_d.level = ~en_eff & (st_q == ST_RUN);
   assign en_d.clear = 1'b0;
   assign ov_d.level = ov_s & (st_q != ST_RESET) & (st_q != ST_OFF);
   assign ov_d.clear = 1'b0;
   logic uv_any;
   assign uv_any = buck_uv_s | ldo_uv_s | disc_s;
   assign uv_d.level = uv_any;
   assign uv_d.clear = 1'b0;
   persist_filter #(.COUNT(EN_OFF_CYC), .WIDTH(CNT_W)) u_en_filt (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .d(en_d));
   persist_filter #(.COUNT(OV_CYC), .WIDTH(CNT_W)) u_ov_filt (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .d(ov_d));
   persist_filter #(.COUNT(UV_CYC), .WIDTH(CNT_W)) u_uv_filt (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .d(uv_d));

   // overvoltage latch: only an enable cycle (enable low with soft-start low) releases it
   logic ov_latch_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         ov_latch_q <= 1'b0;
      end else if (ov_d.expired) begin
         ov_latch_q <= 1'b1;
      end else if (!en_eff && ss_low_s) begin
         ov_latch_q <= 1'b0;
      end
   end

   // sequencer state machine
   shut_step_t sd_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         st_q <= ST_RESET;
         sd_q <= SD_LDO;
      end else if (mrst_s || ov_latch_q) begin
         st_q <= ST_RESET;
      end else begin
         case (st_q)
            ST_RESET: st_q <= ST_OFF;
            ST_OFF: if (en_eff && !ss_low_s) st_q <= ST_START_PRE;
            ST_START_PRE: begin
               if (!en_eff) st_q <= ST_SHUT;
               else if (!pre_uv_s) st_q <= ST_START_BUCK;
               sd_q <= SD_PRE;
            end
            ST_START_BUCK: begin
               if (!en_eff) st_q <= ST_SHUT;
               else if (!buck_uv_s) st_q <= ST_START_LDO;
               sd_q <= SD_LDO;
            end
            ST_START_LDO: begin
               if (!en_eff) st_q <= ST_SHUT;
               else if (!ldo_uv_s) st_q <= ST_RUN;
               sd_q <= SD_LDO;
            end
            ST_RUN: begin
               if (en_d.expired) st_q <= ST_SHUT;
               sd_q <= SD_LDO;
            end
            ST_SHUT: begin
               case (sd_q)
                  SD_LDO: if (ldo_uv_s) sd_q <= SD_PRE;
                  SD_PRE: if (buck_uv_s) sd_q <= SD_PAUSE;
                  SD_PAUSE: if (pre_uv_s && ss_low_s) st_q <= ST_OFF;
                  default: sd_q <= SD_LDO;
               endcase
            end
            default: st_q <= ST_RESET;
         endcase
      end
   end

   // regulator enables derived from state
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         pre_regulator_on_o <= 1'b0;
         buck_on_o <= 1'b0;
         ldos_on_o <= 1'b0;
      end else begin
         pre_regulator_on_o <= (st_q == ST_START_PRE) || (st_q == ST_START_BUCK) ||
                               (st_q == ST_START_LDO) || (st_q == ST_RUN) ||
                               ((st_q == ST_SHUT) && (sd_q != SD_PAUSE));
         buck_on_o <= (st_q == ST_START_BUCK) || (st_q == ST_START_LDO) ||
                      (st_q == ST_RUN) || ((st_q == ST_SHUT) && (sd_q == SD_LDO));
         ldos_on_o <= (st_q == ST_START_LDO) || (st_q == ST_RUN);
      end
   end

   // reset and five-good outputs; faults other than overvoltage drop reset without latching, five-good only on 5v, tracking, disconnect or overvoltage faults
   logic rst_ok, five_ok;
   assign rst_ok = (st_q == ST_RUN) && !uv_any && !tsd_s && !hic_s && !wd_s2_q &&
                   !ov_latch_q;
   assign five_ok = (st_q == ST_RUN) && !uv5_s && !trk_uv_s && !disc_s;
   logic rose_q;
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         power_good_reset_n_o <= 1'b0;
         five_volt_good_o <= 1'b0;
      end else begin
         power_good_reset_n_o <= rst_ok;
         five_volt_good_o <= five_ok;
      end
   end

   // fault code latch, captured on the falling reset output
   logic [1:0] code_q;
   logic fall;
   assign fall = power_good_reset_n_o && !rst_ok;
   // undervoltage class waits out the flag delay so a later hiccup still wins
   logic pend_q, cap_now, cls_ready;
   assign cap_now = (fall && rose_q && code_q == CODE_NONE) || (pend_q && en_s);
   assign cls_ready = hic_s || tsd_s || wd_s2_q || uv_d.expired || ov_latch_q;
   logic [1:0] class_now;
   always_comb begin
      if (hic_s || tsd_s) class_now = CODE_HICCUP;
      else if (wd_s2_q) class_now = CODE_WDOG;
      else class_now = CODE_UV;
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         code_q <= CODE_NONE;
         rose_q <= 1'b0;
         pend_q <= 1'b0;
      end else begin
         if (rst_ok) rose_q <= 1'b1;
         if (cap_now && cls_ready) begin
            code_q <= class_now;
            pend_q <= 1'b0;
         end else if (cap_now) begin
            pend_q <= 1'b1;
         end else if (!en_s && ss_low_s) begin
            code_q <= CODE_NONE;
            rose_q <= 1'b0;
            pend_q <= 1'b0;
         end
      end
   end
   // open drain: pin output always low, enable drives the low level
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         fault_code_bit0_oe_o <= 1'b0;
         fault_code_bit1_oe_o <= 1'b0;
      end else begin
         fault_code_bit0_oe_o <= ~code_q[0];
         fault_code_bit1_oe_o <= ~code_q[1];
      end
   end
   always_ff @(posedge mclk_i) begin
      fault_code_bit0_o <= 1'b0;
      fault_code_bit1_o <= 1'b0;
   end

   // interrupt events
   logic [EV_W-1:0] ev, irq_stat_q, irq_mask_q;
   assign ev = {ov_d.expired & ~ov_latch_q, (st_q == ST_SHUT) && (sd_q == SD_PAUSE) &&
                pre_uv_s && ss_low_s, rst_ok & ~power_good_reset_n_o, fall};

   // ahb-lite slave: zero wait states, always okay
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic take;
   assign take = hsel_i && hready_i && htrans_i[1];
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_o <= 32'h0000_0000;
      end else begin
         wr_pend_q <= take && hwrite_i;
         if (take) wr_addr_q <= haddr_i[7:0];
         if (take && !hwrite_i) begin
            case (haddr_i[7:0])
               OFF_CTRL: hrdata_o <= {31'h0, sw_off_q};
               OFF_STATUS: hrdata_o <= {18'h0, code_q, rose_q, ov_latch_q,
                                        power_good_reset_n_o, five_volt_good_o, 1'b0, st_q};
               OFF_IRQ_STAT: hrdata_o <= {28'h0, irq_stat_q};
               OFF_IRQ_MASK: hrdata_o <= {28'h0, irq_mask_q};
               default: hrdata_o <= 32'h0000_0000;
            endcase
         end
      end
   end
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         hreadyout_o <= 1'b0;
         hresp_o <= 1'b0;
      end else begin
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end
   // register writes; set beats write-one-clear
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) begin
         sw_off_q <= 1'b0;
         irq_mask_q <= EV_ZERO;
         irq_stat_q <= EV_ZERO;
      end else begin
         if (wr_pend_q && wr_addr_q == OFF_CTRL) sw_off_q <= hwdata_i[0];
         if (wr_pend_q && wr_addr_q == OFF_IRQ_MASK) irq_mask_q <= hwdata_i[EV_W-1:0];
         if (wr_pend_q && wr_addr_q == OFF_IRQ_STAT)
            irq_stat_q <= (irq_stat_q & ~hwdata_i[EV_W-1:0]) | ev;
         else
            irq_stat_q <= irq_stat_q | ev;
      end
   end
   // a set mask bit hides its event from the interrupt line
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i) irq_o <= 1'b0;
      else irq_o <= |(irq_stat_q & ~irq_mask_q);
   end

   // checks
   a_mreset_all_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      mrst_s |-> ##2 (!pre_regulator_on_o && !buck_on_o && !ldos_on_o))
      else $error("regulators on under master reset");
   a_ldo_after_buck: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ldos_on_o |-> buck_on_o && pre_regulator_on_o)
      else $error("ldo enabled ahead of buck");
   a_ov_latch_off: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      ov_latch_q |=> !power_good_reset_n_o)
      else $error("reset output high during overvoltage latch");
   a_five_low_uv: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      uv5_s |=> !five_volt_good_o && !power_good_reset_n_o)
      else $error("five-good high during 5v undervoltage");
   a_buck_uv_rst: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      buck_uv_s |=> !power_good_reset_n_o)
      else $error("reset high during buck undervoltage");
   a_disc_both_low: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      disc_s |=> !power_good_reset_n_o && !five_volt_good_o)
      else $error("outputs high during disconnect");
   a_flag_clear: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (!en_s && ss_low_s && !fall) |=> code_q == CODE_NONE)
      else $error("fault code not cleared");
   a_flag_held: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (code_q != CODE_NONE && en_s) |=> $stable(code_q))
      else $error("fault code changed while held");
   a_hiccup_wins: assert property (@(posedge mclk_i) disable iff (!rst_n_i)
      (fall && rose_q && code_q == CODE_NONE && hic_s) |=> code_q == CODE_HICCUP)
      else $error("hiccup not given precedence");
endmodule

// ==== inc/seq_pkg.sv ====
// shared constants and types for the supervisory sequencer
// assumes a single 125 MHz clock and word-wide ahb-lite register access
package seq_pkg;
   localparam int unsigned CLK_MHZ = 125;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_STATUS = 8'h04;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h0c;
   // fault code encodings, bit0 in [0]; a one means released (hi-z)
   localparam logic [1:0] CODE_UV = 2'h0;
   localparam logic [1:0] CODE_HICCUP = 2'h2;
   localparam logic [1:0] CODE_WDOG = 2'h1;
   localparam logic [1:0] CODE_NONE = 2'h3;
   // interrupt event bit positions
   localparam int unsigned EV_FAULT = 0;
   localparam int unsigned EV_RUN = 1;
   localparam int unsigned EV_OFF = 2;
   localparam int unsigned EV_OV = 3;
   localparam int unsigned EV_W = 4;
   localparam logic [EV_W-1:0] EV_ZERO = 4'h0;
   // default timings in ns
   localparam int unsigned FLAG_UV_DLY_NS = 2000;
   localparam int unsigned OV_DLY_NS = 1000;
   localparam int unsigned EN_OFF_DLY_NS = 65000;
   localparam int unsigned CNT_W = 16;
   function automatic int unsigned ns_to_cyc(input int unsigned ns);
      int unsigned c;
      c = (ns * CLK_MHZ + 999) / 1000;
      return (c == 0) ? 1 : c;
   endfunction
   typedef enum logic [6:0] {
      ST_RESET = 7'h01,
      ST_OFF = 7'h02,
      ST_START_PRE = 7'h04,
      ST_START_BUCK = 7'h08,
      ST_START_LDO = 7'h10,
      ST_RUN = 7'h20,
      ST_SHUT = 7'h40
   } seq_state_t;
   typedef enum logic [2:0] {
      SD_LDO = 3'h1,
      SD_PRE = 3'h2,
      SD_PAUSE = 3'h4
   } shut_step_t;
endpackage

// ==== inc/delay_if.sv ====
// carrier between the sequencer and its persistence filter
// assumes both ends on mclk_i
`timescale 1ns/1ns
interface delay_if;
   logic level;
   logic clear;
   logic expired;
   modport owner (output level, output clear, input expired);
   modport filter (input level, input clear, output expired);
endinterface

// ==== rtl/persist_filter.sv ====
// persistence filter: reports once a level has held for a set count
// assumes a synchronous level input on mclk_i
`timescale 1ns/1ns
module persist_filter #(
   parameter int unsigned COUNT = 16,
   parameter int unsigned WIDTH = 16
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   delay_if.filter d
);
   initial begin
      if (COUNT < 1 || COUNT >= (1 << WIDTH)) $error("persist_filter count out of range");
   end
   localparam logic [WIDTH-1:0] LIMIT = WIDTH'(COUNT);
   logic [WIDTH-1:0] cnt_q;
   // count held cycles; saturates so expired stays high
   always_ff @(posedge mclk_i) begin
      if (!rst_n_i || !d.level || d.clear) begin
         cnt_q <= '0;
      end else if (cnt_q != LIMIT) begin
         cnt_q <= cnt_q + 1'b1;
      end
   end
   assign d.expired = d.level && !d.clear && (cnt_q == LIMIT);
endmodule

// ==== test/host_model.sv ====
// host model: watches the reset line and reads the two fault pins
// assumes both pins pulled up on the board, shares mclk_i with the device
`timescale 1ns/1ns
module host_model #(
   parameter int unsigned READ_DLY = 300
) (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic power_good_reset_n_i,
   input wire logic fault_code_bit0_oe_i,
   input wire logic fault_code_bit1_oe_i,
   output logic [1:0] code_o,
   output logic seen_o
);
   logic armed_q;
   logic [9:0] wait_q;
   logic [1:0] pin_lvl;
   // pull-up wins unless the device sinks the pin
   assign pin_lvl = {~fault_code_bit1_oe_i, ~fault_code_bit0_oe_i};
   // late read after a fall so the class has settled; one read per startup
   always_ff @(posedge mclk_i) begin
      seen_o <= 1'b0;
      if (!rst_n_i) begin
         armed_q <= 1'b0;
         wait_q <= 10'h000;
         code_o <= 2'h3;
      end else if (power_good_reset_n_i) begin
         armed_q <= 1'b1;
         wait_q <= 10'h000;
      end else if (armed_q) begin
         wait_q <= wait_q + 10'h001;
         if (wait_q == READ_DLY[9:0]) begin
            code_o <= pin_lvl;
            seen_o <= 1'b1;
            armed_q <= 1'b0;
         end
      end
   end
endmodule

// ==== test/fault_flag_and_sequencer_bench.sv ====
// self-checking bench for the sequencer and fault classifier
// assumes the host model beside it and a short enable-off filter
`timescale 1ns/1ns
module fault_flag_and_sequencer_bench;
   import seq_pkg::*;
   localparam int unsigned EN_OFF = 20;
   logic mclk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic [2:0] en = 3'h0;
   logic mreset = 1'b0, ss_low = 1'b1, any_ov = 1'b0, disc = 1'b0;
   logic pre_uv = 1'b1, buck_uv = 1'b1, ldo3_uv = 1'b1, ldo5_uv = 1'b1, trk_uv = 1'b1;
   logic hic = 1'b0, thermal_shutdown = 1'b0, wdog = 1'b0, hsel = 1'b0, hwrite = 1'b0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_val;
   logic hready, hresp, pre_on, buck_on, ldos_on, pgood, fgood, b0oe, b1oe, irq, seen;
   logic b0, b1;
   logic [1:0] code;
   logic [31:0] rd_q[$];
   logic [1:0] code_q[$];
   logic [1:0] codes[6] = '{CODE_UV, CODE_UV, CODE_UV, CODE_HICCUP, CODE_WDOG, CODE_HICCUP};
   int err_count = 0;
   int comparisons = 0;
   event rd_ev;

   fault_flag_and_sequencer #(.EN_OFF_CYC(EN_OFF)) dut (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .logic_enable_i(en[0]),
      .ignition_enable_a_i(en[1]), .ignition_enable_b_i(en[2]), .master_reset_i(mreset),
      .soft_start_low_i(ss_low), .pre_regulator_uv_i(pre_uv), .buck_output_uv_i(buck_uv),
      .ldo_3p3_uv_i(ldo3_uv), .ldo_5v_uv_i(ldo5_uv), .tracking_ldo_uv_i(trk_uv),
      .any_ov_i(any_ov), .tracking_ldo_disc_i(disc), .hiccup_i(hic),
      .thermal_shutdown_i(thermal_shutdown), .watchdog_fault_i(wdog), .hsel_i(hsel), .haddr_i(haddr),
      .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
      .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready), .hresp_o(hresp),
      .pre_regulator_on_o(pre_on), .buck_on_o(buck_on), .ldos_on_o(ldos_on),
      .power_good_reset_n_o(pgood), .five_volt_good_o(fgood), .fault_code_bit0_o(b0),
      .fault_code_bit0_oe_o(b0oe), .fault_code_bit1_o(b1), .fault_code_bit1_oe_o(b1oe),
      .irq_o(irq));

   host_model host (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .power_good_reset_n_i(pgood),
      .fault_code_bit0_oe_i(b0oe), .fault_code_bit1_oe_i(b1oe), .code_o(code), .seen_o(seen));

   initial begin
      forever #4 mclk_i = ~mclk_i;
   end

   task automatic check(input logic [31:0] saw, input logic [31:0] exp);
      comparisons++;
      if (saw !== exp) begin
         err_count++;
         $display("mismatch at %0t: saw %h expected %h", $time, saw, exp);
      end
   endtask

   task automatic wrap_up();
      if (err_count == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   function automatic logic pick(input int s);
      case (s)
         0: return pre_on;
         1: return buck_on;
         2: return ldos_on;
         default: return pgood;
      endcase
   endfunction

   // bounded wait for one output, then compare it
   task automatic wt(input int s, input logic v);
      int n;
      n = 0;
      while (pick(s) !== v && n < 3000) begin
         @(posedge mclk_i);
         n++;
      end
      check(pick(s), v);
   endtask

   // single word transfer; read data taken at the second ready edge
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] exp);
      @(posedge mclk_i);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      if (!wr) rd_q.push_back(exp);
      do @(posedge mclk_i); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge mclk_i); while (hready !== 1'b1);
      if (!wr) begin
         rd_val = hrdata;
         -> rd_ev;
      end
   endtask

   task automatic start_up(input int e);
      @(posedge mclk_i);
      {pre_uv, buck_uv, ldo3_uv, ldo5_uv, trk_uv} <= 5'h1f;
      ss_low <= 1'b0;
      en <= 3'h1 << e;
      wt(0, 1'b1);
      check(buck_on, 1'b0);
      pre_uv <= 1'b0;
      wt(1, 1'b1);
      check(ldos_on, 1'b0);
      buck_uv <= 1'b0;
      wt(2, 1'b1);
      check(pgood, 1'b0);
      {ldo3_uv, ldo5_uv, trk_uv} <= 3'h0;
      wt(3, 1'b1);
   endtask

   // intermediate order checked only for the first three cases, where full is set
   task automatic shut_down(input logic [1:0] c, input logic full);
      @(posedge mclk_i);
      en <= 3'h0;
      if (full) begin
         repeat (EN_OFF) @(posedge mclk_i);
         check(ldos_on, 1'b1);
         wt(2, 1'b0);
         check(buck_on, 1'b1);
      end
      {ldo3_uv, ldo5_uv, trk_uv} <= 3'h7;
      wt(1, 1'b0);
      if (full) check(pre_on, 1'b1);
      buck_uv <= 1'b1;
      wt(0, 1'b0);
      pre_uv <= 1'b1;
      repeat (20) @(posedge mclk_i);
      check({~b1oe, ~b0oe}, c);
      check({b1, b0}, 2'h0);
      ss_low <= 1'b1;
      repeat (6) @(posedge mclk_i);
      check({b1oe, b0oe}, 2'h0);
   endtask

   // result watchers: oldest note against each observed result
   initial begin
      forever begin
         @(rd_ev);
         check(rd_val, rd_q.pop_front());
      end
   end
   initial begin
      forever begin
         @(posedge mclk_i);
         if (seen === 1'b1) check(code, code_q.pop_front());
      end
   end

   initial begin
      repeat (60000) @(posedge mclk_i);
      err_count++;
      wrap_up();
   end

   initial begin
      void'($urandom(87458));
      repeat (8) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      repeat (20) @(posedge mclk_i);
      check({b1oe, b0oe}, 2'h0);
      ahb(1'b1, OFF_IRQ_STAT, 32'hf, 32'h0);
      ahb(1'b1, OFF_IRQ_MASK, 32'h0, 32'h0);
      ahb(1'b1, 8'h40, $urandom, 32'h0);
      ahb(1'b0, 8'h40, 32'h0, 32'h0);
      check(hresp, 1'b0);
      for (int k = 0; k < 6; k++) begin
         start_up(k % 3);
         if (k == 0) begin
            ahb(1'b0, OFF_STATUS, 32'h0, 32'h3b20);
            ahb(1'b0, OFF_IRQ_STAT, 32'h0, 32'h2);
            check(irq, 1'b1);
            ahb(1'b1, OFF_IRQ_MASK, 32'hf, 32'h0);
            repeat (2) @(posedge mclk_i);
            check(irq, 1'b0);
            ahb(1'b1, OFF_IRQ_MASK, 32'h0, 32'h0);
            ahb(1'b1, OFF_IRQ_STAT, 32'h2, 32'h0);
            repeat (2) @(posedge mclk_i);
            check(irq, 1'b0);
         end
         code_q.push_back(codes[k]);
         @(posedge mclk_i);
         case (k)
            0: ldo3_uv <= 1'b1;
            1: ldo5_uv <= 1'b1;
            2: disc <= 1'b1;
            3: buck_uv <= 1'b1;
            4: wdog <= 1'b1;
            default: thermal_shutdown <= 1'b1;
         endcase
         if (k == 3) begin
            repeat (1 + $urandom % 150) @(posedge mclk_i);
            hic <= 1'b1;
         end
         wt(3, 1'b0);
         if (k < 3) check({fgood, pre_on, buck_on, ldos_on}, {k == 0, 3'h7});
         repeat (400) @(posedge mclk_i);
         {ldo3_uv, ldo5_uv, disc, buck_uv, wdog, thermal_shutdown, hic} <= 7'h0;
         if (k < 3) wt(3, 1'b1);
         check({~b1oe, ~b0oe}, codes[k]);
         shut_down(codes[k], k < 3);
      end
      // short overvoltage ignored, persistent one latches everything off
      start_up(0);
      any_ov <= 1'b1;
      repeat (100) @(posedge mclk_i);
      any_ov <= 1'b0;
      repeat (20) @(posedge mclk_i);
      check(pgood, 1'b1);
      code_q.push_back(CODE_UV);
      any_ov <= 1'b1;
      repeat (140) @(posedge mclk_i);
      check({pgood, pre_on, buck_on, ldos_on}, 4'h0);
      any_ov <= 1'b0;
      repeat (400) @(posedge mclk_i);
      check({pgood, pre_on, buck_on, ldos_on}, 4'h0);
      en <= 3'h0;
      {pre_uv, buck_uv, ldo3_uv, ldo5_uv, trk_uv} <= 5'h1f;
      ss_low <= 1'b1;
      repeat (20) @(posedge mclk_i);
      check({b1oe, b0oe}, 2'h0);
      // master reset in mid-startup drops every enable
      ss_low <= 1'b0;
      en <= 3'h4;
      wt(0, 1'b1);
      pre_uv <= 1'b0;
      wt(1, 1'b1);
      mreset <= 1'b1;
      repeat (6) @(posedge mclk_i);
      check({pre_on, buck_on, ldos_on}, 3'h0);
      mreset <= 1'b0;
      wt(0, 1'b1);
      // software force-off walks the partial startup back down
      ahb(1'b1, OFF_CTRL, 32'h1, 32'h0);
      ahb(1'b0, OFF_CTRL, 32'h0, 32'h1);
      wt(0, 1'b0);
      check(code_q.size(), 0);
      wrap_up();
   end
endmodule
